// ===== rtl/flic_pkg.sv
// Package with source indices, vectors and widths of the interrupt controller
package flic_pkg;
    localparam int NUM_SRC = 15;
    localparam int NUM_LVL = 4;
    localparam int VEC_W = 16;
    // Source indices in vector-address order
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TMR0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TMR1 = 3;
    localparam int SRC_UART = 4;
    localparam int SRC_TWI = 5;
    localparam int SRC_CAP0 = 6;
    localparam int SRC_CAP1 = 7;
    localparam int SRC_CAP2 = 8;
    localparam int SRC_CAP3 = 9;
    localparam int SRC_ADC = 10;
    localparam int SRC_CMP0 = 11;
    localparam int SRC_CMP1 = 12;
    localparam int SRC_CMP2 = 13;
    localparam int SRC_TOVF = 14;
    // Vector base and stride
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    // Order within a level, highest first, as source indices
    localparam logic [3:0] POLL_ORDER [NUM_SRC] = '{
        4'h0, 4'h5, 4'hA, 4'h1, 4'h6, 4'hB, 4'h2, 4'h7,
        4'hC, 4'h3, 4'h8, 4'hD, 4'h4, 4'h9, 4'hE};
    // Flag reset value
    localparam logic [14:0] FLAG_RST = 15'h0000;
    localparam logic [3:0] STACK_RST = 4'h0;
endpackage

// ===== rtl/flic_sel_if.sv
// Interface carrying pending requests and the arbiter's choice
`timescale 1ns/10ps
interface flic_sel_if;
    import flic_pkg::*;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] prioHi;
    logic [NUM_SRC-1:0] prioLo;
    logic [NUM_LVL-1:0] inService;
    logic found;
    logic [3:0] winSrc;
    logic [1:0] winLvl;
    modport ctl (output pend, prioHi, prioLo, inService, input found, winSrc, winLvl);
    modport arb (input pend, prioHi, prioLo, inService, output found, winSrc, winLvl);
endinterface

// ===== rtl/flic_arbiter.sv
// Combinational arbiter choosing the winning source by level and poll order
`timescale 1ns/10ps
module flic_arbiter
    import flic_pkg::*;
(
    flic_sel_if.arb sel
);
    logic [NUM_SRC-1:0][1:0] lvl;
    logic [2:0] topBusy;

    // Level of each source from its two priority bits
    genvar g;
    for (g = 0; g < NUM_SRC; g++) begin : gLvl
        assign lvl[g] = {sel.prioHi[g], sel.prioLo[g]};
    end

    // Highest level in service plus one, zero when idle
    always_comb begin
        topBusy = 3'h0;
        for (int l = 0; l < NUM_LVL; l++) begin
            if (sel.inService[l]) begin
                topBusy = 3'(l + 1);
            end
        end
    end

    // Highest level wins, poll order breaks ties; must beat the level in service
    always_comb begin
        int s;
        s = 0;
        sel.found = 1'b0;
        sel.winSrc = 4'h0;
        sel.winLvl = 2'h0;
        for (int l = NUM_LVL - 1; l >= 0; l--) begin
            for (int k = 0; k < NUM_SRC; k++) begin
                s = int'(POLL_ORDER[k]);
                if (!sel.found && sel.pend[s] && lvl[s] == 2'(l)
                    && 3'(l) >= topBusy) begin
                    sel.found = 1'b1;
                    sel.winSrc = 4'(s);
                    sel.winLvl = 2'(l);
                end
            end
        end
    end
endmodule

// ===== rtl/flic_top.sv
// Four-level nested interrupt controller with fifteen sources
`timescale 1ns/10ps
module flic_top
    import flic_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // Pin levels, two flops deep before any logic reads them
    input wire logic extRequest0,
    input wire logic extRequest1,
    input wire logic [3:0] captureInput,
    // Same-clock events from peripheral logic
    input wire logic timer0Ovf,
    input wire logic timer1Ovf,
    input wire logic uartReceiveFlag,
    input wire logic uartTransmitFlag,
    input wire logic twowireStatusLoad,
    input wire logic twowireStatusValid,
    input wire logic converterDone,
    input wire logic [15:0] timerValue,
    input wire logic [15:0] compareReg0,
    input wire logic [15:0] compareReg1,
    input wire logic [15:0] compareReg2,
    input wire logic byteOvf,
    input wire logic wordOvf,
    // Software flag writes
    input wire logic swFlagWrite,
    input wire logic [NUM_SRC-1:0] swFlagMask,
    input wire logic [NUM_SRC-1:0] swFlagData,
    input wire logic swOvfWrite,
    input wire logic [1:0] swOvfMask,
    input wire logic [1:0] swOvfData,
    // Enables and priorities
    input wire logic globalEnableBit,
    input wire logic [NUM_SRC-1:0] srcEnable,
    input wire logic [NUM_SRC-1:0] priorityHighBit,
    input wire logic [NUM_SRC-1:0] priorityLowBit,
    // Core handshake
    input wire logic intAck,
    input wire logic intReturn,
    output logic intReq,
    output logic [VEC_W-1:0] intVector,
    output logic [NUM_SRC-1:0] flagStatus,
    output logic [NUM_LVL-1:0] inServiceStatus
);
    // ************************************************
    // Input synchronisers and edge detection
    // ************************************************
    logic [5:0] pinMeta_q;
    logic [5:0] pinSync_q;
    logic [5:0] pinLast_q;
    logic [5:0] pinRise;
    logic cmpHit0_q;
    logic cmpHit1_q;
    logic cmpHit2_q;

    // Two flops on every pin input
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta_q <= 6'h00;
            pinSync_q <= 6'h00;
            pinLast_q <= 6'h00;
        end else begin
            pinMeta_q <= {captureInput, extRequest1, extRequest0};
            pinSync_q <= pinMeta_q;
            pinLast_q <= pinSync_q;
        end
    end
    assign pinRise = pinSync_q & ~pinLast_q;

    // Compare matches, edge-qualified so a held match sets once per entry
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmpHit0_q <= 1'b0;
            cmpHit1_q <= 1'b0;
            cmpHit2_q <= 1'b0;
        end else begin
            cmpHit0_q <= (timerValue == compareReg0);
            cmpHit1_q <= (timerValue == compareReg1);
            cmpHit2_q <= (timerValue == compareReg2);
        end
    end

    // ************************************************
    // Request flags
    // ************************************************
    logic [NUM_SRC-1:0] hwSet;
    logic [NUM_SRC-1:0] flag_q;
    logic [NUM_SRC-1:0] flag_d;
    logic byteOvfFlag_q;
    logic wordOvfFlag_q;
    logic ackClear;
    logic [3:0] winSrcQ;
    logic [1:0] winLvlQ;

    // Hardware set events per source
    always_comb begin
        hwSet = '0;
        hwSet[SRC_EXT0] = pinRise[0];
        hwSet[SRC_EXT1] = pinRise[1];
        hwSet[SRC_TMR0] = timer0Ovf;
        hwSet[SRC_TMR1] = timer1Ovf;
        hwSet[SRC_CAP0] = pinRise[2];
        hwSet[SRC_CAP1] = pinRise[3];
        hwSet[SRC_CAP2] = pinRise[4];
        hwSet[SRC_CAP3] = pinRise[5];
        hwSet[SRC_CMP0] = (timerValue == compareReg0) && !cmpHit0_q;
        hwSet[SRC_CMP1] = (timerValue == compareReg1) && !cmpHit1_q;
        hwSet[SRC_CMP2] = (timerValue == compareReg2) && !cmpHit2_q;
        hwSet[SRC_TWI] = twowireStatusLoad && twowireStatusValid;
        hwSet[SRC_ADC] = converterDone;
    end

    // Next flag value: hardware set wins over software clear
    always_comb begin
        flag_d = flag_q;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (swFlagWrite && swFlagMask[i]) begin
                if (i == SRC_ADC) begin
                    flag_d[i] = flag_q[i] & swFlagData[i];
                end else begin
                    flag_d[i] = swFlagData[i];
                end
            end
            // Only external and timer flags clear on vectoring; capture timer,
            // converter and two-wire flags stay until software clears them
            if (ackClear && int'(winSrcQ) == i && (i == SRC_EXT0 || i == SRC_EXT1
                || i == SRC_TMR0 || i == SRC_TMR1)) begin
                flag_d[i] = 1'b0;
            end
            if (hwSet[i]) begin
                flag_d[i] = 1'b1;
            end
        end
        // UART and overflow requests are live ORs of their own flags
        flag_d[SRC_UART] = 1'b0;
        flag_d[SRC_TOVF] = 1'b0;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Byte and word overflow flags, software write with set priority
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byteOvfFlag_q <= 1'b0;
            wordOvfFlag_q <= 1'b0;
        end else begin
            if (byteOvf) begin
                byteOvfFlag_q <= 1'b1;
            end else if (swOvfWrite && swOvfMask[0]) begin
                byteOvfFlag_q <= swOvfData[0];
            end
            if (wordOvf) begin
                wordOvfFlag_q <= 1'b1;
            end else if (swOvfWrite && swOvfMask[1]) begin
                wordOvfFlag_q <= swOvfData[1];
            end
        end
    end

    // Full request vector: eight capture-timer requests among fifteen
    logic [NUM_SRC-1:0] request;
    always_comb begin
        request = flag_q;
        request[SRC_UART] = uartReceiveFlag | uartTransmitFlag;
        request[SRC_TOVF] = byteOvfFlag_q | wordOvfFlag_q;
    end

    // ************************************************
    // Arbitration and in-service stack
    // ************************************************
    flic_sel_if sel ();
    logic [NUM_LVL-1:0] inSvc_q;
    logic reqPending;

    assign sel.pend = request & srcEnable
        & {NUM_SRC{globalEnableBit}};
    assign sel.prioHi = priorityHighBit;
    assign sel.prioLo = priorityLowBit;
    assign sel.inService = inSvc_q;

    flic_arbiter uArb (
        .sel(sel)
    );

    assign ackClear = intAck && intReq;
    assign reqPending = sel.found;

    // Stack of levels in service: ack pushes, return pops the top one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            inSvc_q <= STACK_RST;
        end else if (ackClear) begin
            inSvc_q[winLvlQ] <= 1'b1;
        end else if (intReturn) begin
            for (int l = 0; l < NUM_LVL; l++) begin
                if (inSvc_q[l] && ((inSvc_q >> (l + 1)) == '0)) begin
                    inSvc_q[l] <= 1'b0;
                end
            end
        end
    end

    // Request and vector outputs registered from the arbiter
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intReq <= 1'b0;
            intVector <= VEC_BASE;
            winSrcQ <= 4'h0;
            winLvlQ <= 2'h0;
        end else begin
            intReq <= reqPending && !ackClear && !intReturn;
            winSrcQ <= sel.winSrc;
            winLvlQ <= sel.winLvl; // Level travels with the vector the core takes
            intVector <= VEC_BASE + VEC_STEP * {12'h000, sel.winSrc};
        end
    end

    // Status mirrors
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flagStatus <= FLAG_RST;
            inServiceStatus <= STACK_RST;
        end else begin
            flagStatus <= request;
            inServiceStatus <= inSvc_q;
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    a_adc_no_swset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!flag_q[SRC_ADC] && !converterDone) |=> !flag_q[SRC_ADC])
        else $error("converter flag set without hardware event");
    a_cap_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flag_q[SRC_CAP0] && !(swFlagWrite && swFlagMask[SRC_CAP0])) |=> flag_q[SRC_CAP0])
        else $error("capture flag cleared by hardware");
    a_ovf_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        byteOvf |=> byteOvfFlag_q)
        else $error("byte overflow did not set flag");
    a_global_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !globalEnableBit |=> !intReq)
        else $error("request while globally disabled");
    a_twi_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (twowireStatusLoad && twowireStatusValid) |=> flag_q[SRC_TWI])
        else $error("two-wire flag not set");
    a_vector_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 intVector == VEC_BASE + 16'(8 * int'($past(sel.winSrc))))
        else $error("vector does not match source");
    a_uart_or: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (uartReceiveFlag || uartTransmitFlag) |=> flagStatus[SRC_UART])
        else $error("uart request not an OR");
    a_no_equal_preempt: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sel.found && inSvc_q != '0) |-> !inSvc_q[sel.winLvl])
        else $error("winner level already in service");
    a_return_pops: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (intReturn && !ackClear && inSvc_q[3]) |=> !inSvc_q[3])
        else $error("return did not release top level");
    a_ack_push: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ackClear |=> inSvc_q[$past(winLvlQ)])
        else $error("taken level not marked in service");
    a_preempt_higher: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ackClear && inSvc_q != '0) |-> ((4'h1 << winLvlQ) > inSvc_q))
        else $error("taken level not above levels in service");
    a_cmp_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((timerValue == compareReg0) && !cmpHit0_q) |=> flag_q[SRC_CMP0])
        else $error("compare match did not set flag");
    a_adc_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        converterDone |=> flag_q[SRC_ADC])
        else $error("conversion done did not set flag");
    a_sw_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (swFlagWrite && swFlagMask[SRC_EXT0] && !swFlagData[SRC_EXT0] && !hwSet[SRC_EXT0])
        |=> !flag_q[SRC_EXT0])
        else $error("software clear of external flag lost");
    a_pend_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(intReq) |-> $past(globalEnableBit && (srcEnable != '0)))
        else $error("request raised without enables");
endmodule

// ===== tb/flic_core_model.sv
// Behavioural processor core that takes interrupts and signals returns
`timescale 1ns/10ps
module flic_core_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic intReq,
    input wire logic hold,
    input wire logic retCmd,
    output logic intAck,
    output logic intReturn
);
    // Ack one cycle after a request is seen, held off while stalled
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            intAck <= 1'b0;
            intReturn <= 1'b0;
        end else begin
            intAck <= #2 intReq && !intAck && !hold;
            intReturn <= #2 retCmd; // End of service routine
        end
    end
endmodule

// ===== tb/flic_top_tb.sv
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/10ps
module flic_top_tb;
    import flic_pkg::*;
    // ****************************************
    // Signals, instances and shared tasks
    // ****************************************
    logic clk_sys = 1'b0, rst_n = 1'b0, hold = 1'b1, retCmd = 1'b0;
    logic extRequest0 = 1'b0, extRequest1 = 1'b0, timer0Ovf = 1'b0, timer1Ovf = 1'b0;
    logic uartReceiveFlag = 1'b0, uartTransmitFlag = 1'b0, converterDone = 1'b0;
    logic twowireStatusLoad = 1'b0, twowireStatusValid = 1'b0, byteOvf = 1'b0, wordOvf = 1'b0;
    logic swFlagWrite = 1'b0, swOvfWrite = 1'b0, globalEnableBit = 1'b1;
    logic [3:0] captureInput = 4'h0;
    logic [1:0] swOvfMask = 2'h0, swOvfData = 2'h0;
    logic [15:0] timerValue = 16'h0000, compareReg0 = 16'hFFFF, compareReg1 = 16'hFFFF;
    logic [15:0] compareReg2 = 16'hFFFF, v;
    logic [14:0] swFlagMask = 15'h0000, swFlagData = 15'h0000, srcEnable = 15'h7FFF;
    logic [14:0] priorityHighBit = 15'h0000, priorityLowBit = 15'h0000;
    logic intAck, intReturn, intReq;
    logic [VEC_W-1:0] intVector;
    logic [NUM_SRC-1:0] flagStatus;
    logic [NUM_LVL-1:0] inServiceStatus;
    logic [15:0] expQ[$];
    int bad_count = 0, n_checks = 0, seed = 31962;

    flic_top flic_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .extRequest0(extRequest0),
        .extRequest1(extRequest1), .captureInput(captureInput), .timer0Ovf(timer0Ovf),
        .timer1Ovf(timer1Ovf), .uartReceiveFlag(uartReceiveFlag),
        .uartTransmitFlag(uartTransmitFlag), .twowireStatusLoad(twowireStatusLoad),
        .twowireStatusValid(twowireStatusValid), .converterDone(converterDone),
        .timerValue(timerValue), .compareReg0(compareReg0), .compareReg1(compareReg1),
        .compareReg2(compareReg2), .byteOvf(byteOvf), .wordOvf(wordOvf),
        .swFlagWrite(swFlagWrite), .swFlagMask(swFlagMask), .swFlagData(swFlagData),
        .swOvfWrite(swOvfWrite), .swOvfMask(swOvfMask), .swOvfData(swOvfData),
        .globalEnableBit(globalEnableBit), .srcEnable(srcEnable),
        .priorityHighBit(priorityHighBit), .priorityLowBit(priorityLowBit), .intAck(intAck),
        .intReturn(intReturn), .intReq(intReq), .intVector(intVector),
        .flagStatus(flagStatus), .inServiceStatus(inServiceStatus));
    flic_core_model flic_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .intReq(intReq),
        .hold(hold), .retCmd(retCmd), .intAck(intAck), .intReturn(intReturn));

    // Clock at 10 MHz
    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        n_checks++;
        if (seen !== expv) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [15:0] vecOf(input logic [3:0] s);
        return VEC_BASE + VEC_STEP * {12'h000, s};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic swWr(input logic [14:0] m, input logic [14:0] d);
        swFlagMask = m;
        swFlagData = d;
        swFlagWrite = 1'b1;
        cyc(1);
        swFlagWrite = 1'b0;
        cyc(1);
    endtask
    task automatic ovfWr(input logic [1:0] m, input logic [1:0] d);
        swOvfMask = m;
        swOvfData = d;
        swOvfWrite = 1'b1;
        cyc(1);
        swOvfWrite = 1'b0;
        cyc(1);
    endtask
    task automatic ret();
        retCmd = 1'b1;
        cyc(1);
        retCmd = 1'b0;
        cyc(3);
    endtask
    // Bounded wait until the core has taken every noted vector
    task automatic drain();
        for (int k = 0; k < 60 && expQ.size() != 0; k++) cyc(1);
        chk(16'(expQ.size()), 16'h0000);
        cyc(1); // Let the in-service mirror catch up with the push
    endtask

    // Compare each vector the core takes with the oldest noted one
    always @(posedge clk_sys) begin
        if (rst_n && intAck === 1'b1 && intReq === 1'b1) begin
            if (expQ.size() == 0) chk(intVector, 16'hFFFF);
            else chk(intVector, expQ.pop_front());
        end
    end

    // Watchdog against a hung handshake
    initial begin
        #2000000;
        bad_count++;
        conclude();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(2);
        // All fifteen sources pending at one level drain in poll order
        swWr(15'h3BEF, 15'h3BEF);
        uartReceiveFlag = 1'b1;
        converterDone = 1'b1;
        byteOvf = 1'b1;
        cyc(1);
        converterDone = 1'b0;
        byteOvf = 1'b0;
        cyc(3);
        chk(16'(flagStatus), 16'h7FFF);
        for (int k = 0; k < NUM_SRC; k++) begin
            expQ.push_back(vecOf(POLL_ORDER[k]));
            hold = 1'b0;
            drain();
            if (POLL_ORDER[k] == 4'h4) uartReceiveFlag = 1'b0;
            else if (POLL_ORDER[k] == 4'hE) ovfWr(2'h3, 2'h0);
            else swWr(15'h0001 << POLL_ORDER[k], 15'h0000);
            ret();
        end
        // Software cannot set the converter flag; enables gate requests
        hold = 1'b1;
        swWr(15'h0400, 15'h0400);
        chk(16'(flagStatus), 16'h0000);
        globalEnableBit = 1'b0;
        swWr(15'h0002, 15'h0002);
        cyc(3);
        chk(16'(intReq), 16'h0000);
        globalEnableBit = 1'b1;
        srcEnable = 15'h7FFD;
        cyc(3);
        chk(16'(intReq), 16'h0000);
        srcEnable = 15'h7FFF;
        cyc(3);
        chk(16'(intReq), 16'h0001);
        swWr(15'h0002, 15'h0000);
        cyc(3);
        hold = 1'b0;
        // Nesting: level 1 served, level 3 preempts, equal level waits
        priorityLowBit = 15'h01C0;
        priorityHighBit = 15'h0080;
        expQ.push_back(vecOf(4'h6));
        swWr(15'h0040, 15'h0040);
        drain();
        chk(16'(inServiceStatus), 16'h0002);
        swWr(15'h0100, 15'h0100);
        cyc(4);
        chk(16'(intReq), 16'h0000);
        expQ.push_back(vecOf(4'h7));
        swWr(15'h0080, 15'h0080);
        drain();
        chk(16'(inServiceStatus), 16'h000A);
        swWr(15'h00C0, 15'h0000);
        ret();
        chk(16'(inServiceStatus), 16'h0002);
        chk(16'(intReq), 16'h0000);
        expQ.push_back(vecOf(4'h8));
        ret();
        drain();
        swWr(15'h0100, 15'h0000);
        ret();
        chk(16'(inServiceStatus), 16'h0000);
        // Hardware events set flags, which then stay set
        hold = 1'b1;
        v = 16'($random(seed));
        compareReg0 = v;
        compareReg1 = v;
        compareReg2 = v;
        cyc(2);
        timerValue = v;
        captureInput = 4'hF;
        extRequest0 = 1'b1;
        extRequest1 = 1'b1;
        twowireStatusLoad = 1'b1;
        timer1Ovf = 1'b1;
        cyc(1);
        twowireStatusLoad = 1'b0;
        timer1Ovf = 1'b0;
        cyc(5);
        chk(16'(flagStatus), 16'h3BCD);
        twowireStatusValid = 1'b1;
        twowireStatusLoad = 1'b1;
        cyc(1);
        twowireStatusLoad = 1'b0;
        cyc(12);
        chk(16'(flagStatus), 16'h3BED);
        uartTransmitFlag = 1'b1;
        wordOvf = 1'b1;
        cyc(1);
        wordOvf = 1'b0;
        cyc(3);
        chk(16'(flagStatus), 16'h7BFD);
        uartTransmitFlag = 1'b0;
        swWr(15'h7FFF, 15'h0000);
        ovfWr(2'h3, 2'h0);
        cyc(3);
        chk(16'(flagStatus), 16'h0000);
        ovfWr(2'h2, 2'h2);
        cyc(3);
        chk(16'(flagStatus), 16'h4000);
        conclude();
    end
endmodule
